// ===== inc/ccr_regs.vh
// Register indices, field positions, reset values and timing counts for the
// converter configuration register bank.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef CCR_REGS_VH
`define CCR_REGS_VH

// Register indices; byte address is four times the index
`define CCR_IDX_LIMIT_SLEW 4'h5
`define CCR_IDX_VOUT0 4'h6
`define CCR_IDX_VOUT1 4'h7
`define CCR_IDX_STEP_UP 4'h8
`define CCR_IDX_DELAY0 4'h9
`define CCR_IDX_BUCK0_CTRL 4'hC
`define CCR_IDX_GLOBAL_CFG 4'hD
`define CCR_IDX_STATUS 4'hE

// Constant reset values; all but the first buck control and global config values are overwritten by the one-time memory load
`define CCR_RST_LIMIT_SLEW 8'h1A
`define CCR_RST_VOUT0 8'h00
`define CCR_RST_VOUT1 8'h00
`define CCR_RST_STEP_UP 8'h08
`define CCR_RST_DELAY0 8'h00
`define CCR_RST_BUCK0_CTRL 8'h00
`define CCR_RST_GLOBAL_CFG 8'h00

// Field positions
`define CCR_ILIM_MSB 5
`define CCR_ILIM_LSB 3
`define CCR_SLEW_MSB 2
`define CCR_SLEW_LSB 0
`define CCR_SU_VSET_MSB 7
`define CCR_SU_VSET_LSB 6
`define CCR_SU_DISCH_BIT 3
`define CCR_PINSEL_MSB 2
`define CCR_PINSEL_LSB 1
`define CCR_EN_BIT 0
`define CCR_OFF_DLY_MSB 7
`define CCR_OFF_DLY_LSB 4
`define CCR_ON_DLY_MSB 3
`define CCR_ON_DLY_LSB 0
`define CCR_SCALE_BIT 0

// Code limits and values
`define CCR_ILIM_MAX 3'h6
`define CCR_SLEW_MIN 3'h2
`define CCR_ILIM_BASE_MA 13'h05DC
`define CCR_ILIM_STEP_MA 13'h01F4
`define CCR_SU_BASE_MV 13'h1324
`define CCR_SU_STEP_MV 13'h0064
`define CCR_V_SEG1_CODE 8'h14
`define CCR_V_SEG2_CODE 8'h18
`define CCR_V_SEG3_CODE 8'h9E
`define CCR_V_SEG1_MV 12'h2BC
`define CCR_V_SEG2_MV 12'h2DF
`define CCR_V_SEG3_MV 12'h58C
`define CCR_V_SEG1_STEP 12'h00A
`define CCR_V_SEG2_STEP 12'h005
`define CCR_V_SEG3_STEP 12'h014

// Timing: delay step in microseconds and clock rate in MHz
`define CCR_STEP_US 500
`define CCR_CLK_MHZ 100
`define CCR_STEP_CYCLES (`CCR_STEP_US * `CCR_CLK_MHZ)

`endif

// ===== hdl/ccr_delay_timer.v
// Startup and shutdown delay sequencer for one converter.
// Assumes a control level on the same clock and static delay codes while
// a wait runs; a code change mid-wait takes effect only at the next control edge.
`timescale 1ns/1ps
`include "ccr_regs.vh"

module ccr_delay_timer #(
   parameter STEP_CYCLES = `CCR_STEP_CYCLES
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Control and delay settings
   input wire ctrl,
   input wire [3:0] on_delay,
   input wire [3:0] off_delay,
   input wire scale,
   // Converter on state
   output reg active_q
);

   localparam integer STEP_LAST_FULL = STEP_CYCLES - 1; // Prescaler end at full width
   localparam [16:0] STEP_LAST = STEP_LAST_FULL[16:0]; // Cut on purpose; one step fits 17 bits

   reg ctrl_q; // Last seen control level
   reg pend_q; // A wait is running
   reg [4:0] steps_q; // Delay steps still to go
   reg [16:0] pre_q; // Cycle count inside one step
   wire [3:0] code = ctrl ? on_delay : off_delay;
   wire [4:0] load = scale ? {code, 1'b0} : {1'b0, code}; // Doubled steps when scaled

   ////////////////////////////////////////////////////////////////////////
   // Each edge restarts the step prescaler so a wait is exact to one cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= 1'b0;
         pend_q <= 1'b0;
         steps_q <= 5'h00;
         pre_q <= 17'h00000;
         active_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl;
         if (ctrl != ctrl_q) begin
            // Edge of control: a reversal abandons the running wait
            pend_q <= 1'b1;
            steps_q <= load;
            pre_q <= 17'h00000;
         end else if (pend_q) begin
            if (steps_q == 5'h00) begin
               // Delay elapsed: follow the control level
               active_q <= ctrl_q;
               pend_q <= 1'b0;
            end else if (pre_q == STEP_LAST) begin
               pre_q <= 17'h00000;
               steps_q <= steps_q - 5'h01;
            end else begin
               pre_q <= pre_q + 17'h00001;
            end
         end
      end
   end

endmodule

// ===== hdl/ccr_top.v
// Configuration register bank for two buck converters and a step-up
// converter, reached over an Avalon-MM slave with waitrequest.
// Assumes the one-time memory defaults are stable from reset release and the
// enable pins are asynchronous to REF_CLK.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ccr_regs.vh"

module ccr_top #(
   parameter STEP_CYCLES = `CCR_STEP_CYCLES
) (
   // Clock and reset
   input wire REF_CLK,
   input wire RESET_N,
   // Avalon-MM slave
   input wire [5:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [3:0] AVS_BYTEENABLE,
   input wire [31:0] AVS_WRITEDATA,
   output wire [31:0] AVS_READDATA,
   output wire AVS_WAITREQUEST,
   // One-time memory defaults
   input wire [7:0] OTP_LIMIT_SLEW,
   input wire [7:0] OTP_VOUT0,
   input wire [7:0] OTP_VOUT1,
   input wire [7:0] OTP_STEP_UP,
   input wire [7:0] OTP_DELAY0,
   // External enable pins
   input wire ENABLE_PIN_ONE,
   input wire ENABLE_PIN_TWO,
   input wire ENABLE_PIN_THREE,
   // Second buck converter settings
   output reg [2:0] SECOND_CONVERTER_PEAK_CURRENT_LIMIT,
   output reg [12:0] SECOND_CONVERTER_LIMIT_MA,
   output reg [2:0] SECOND_CONVERTER_RAMP_RATE,
   // Buck voltage targets in millivolts
   output reg [11:0] FIRST_CONVERTER_TARGET_MV,
   output reg [11:0] SECOND_CONVERTER_TARGET_MV,
   // Step-up converter
   output reg [12:0] STEP_UP_TARGET_MV,
   output reg STEP_UP_ON,
   output reg STEP_UP_DISCHARGE,
   // First buck converter sequenced on state
   output wire FIRST_CONVERTER_ON
);

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // True when a byte address selects a register index on a word boundary
   function hit;
      input [5:0] addr;
      input [3:0] idx;
      begin
         hit = (addr[5:2] == idx) && (addr[1:0] == 2'b00);
      end
   endfunction

   // Voltage code to millivolts; reserved low codes clamp to the lowest target
   function [11:0] vout_mv;
      input [7:0] c;
      reg [11:0] d;
      begin
         d = 12'h000;
         if (c >= `CCR_V_SEG3_CODE) begin
            d = {4'h0, c - `CCR_V_SEG3_CODE};
            vout_mv = `CCR_V_SEG3_MV + d * `CCR_V_SEG3_STEP;
         end else if (c >= `CCR_V_SEG2_CODE) begin
            d = {4'h0, c - `CCR_V_SEG2_CODE};
            vout_mv = `CCR_V_SEG2_MV + d * `CCR_V_SEG2_STEP;
         end else if (c >= `CCR_V_SEG1_CODE) begin
            d = {4'h0, c - `CCR_V_SEG1_CODE};
            vout_mv = `CCR_V_SEG1_MV + d * `CCR_V_SEG1_STEP;
         end else begin
            // Reserved codes: hold at the bottom of the range for safety
            vout_mv = `CCR_V_SEG1_MV;
         end
      end
   endfunction

   // Pin gating shared by both enable paths
   function gate;
      input en;
      input [1:0] sel;
      input [2:0] pins;
      begin
         if (sel == 2'b00) begin
            gate = en;
         end else begin
            gate = en & pins[sel - 2'b01];
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Storage
   reg [7:0] limit_slew_q; // Second buck limit and ramp rate
   reg [7:0] vout0_q; // First buck voltage code
   reg [7:0] vout1_q; // Second buck voltage code
   reg [7:0] step_up_q; // Step-up control
   reg [7:0] delay0_q; // First buck sequencing delays
   reg [7:0] buck0_ctrl_q; // First buck enable and pin select
   reg [7:0] global_cfg_q; // Delay scale select
   reg loaded_q; // One-time memory defaults taken
   reg ack_q; // Answer cycle of the bus
   reg [7:0] rdata_q; // Registered read data
   reg [2:0] pin_s1_q; // Pin synchroniser, first stage
   reg [2:0] pin_s2_q; // Pin synchroniser, second stage

   wire req = AVS_READ | AVS_WRITE;
   wire take = req & ~ack_q & loaded_q; // Request accepted this cycle
   wire wr_lane = AVS_WRITE & AVS_BYTEENABLE[0]; // Registers sit in lane 0
   wire buck0_ctrl_eff; // Gated first buck control level
   wire step_up_eff; // Gated step-up enable
   reg [7:0] rd_mux; // Read value before the register

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle, answer on the second edge; waits also
   // cover the single load cycle after reset so no write races the defaults
   assign AVS_WAITREQUEST = req & ~ack_q;
   assign AVS_READDATA = {24'h000000, rdata_q};

   always @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= take;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Enable pin synchroniser; only the second stage is read
   always @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
      end else begin
         pin_s1_q <= {ENABLE_PIN_THREE, ENABLE_PIN_TWO, ENABLE_PIN_ONE};
         pin_s2_q <= pin_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes; first cycle after reset takes the one-time defaults.
   // Reset itself uses constants so the memory ports are never sampled
   // asynchronously.
   always @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         limit_slew_q <= `CCR_RST_LIMIT_SLEW;
         vout0_q <= `CCR_RST_VOUT0;
         vout1_q <= `CCR_RST_VOUT1;
         step_up_q <= `CCR_RST_STEP_UP;
         delay0_q <= `CCR_RST_DELAY0;
         buck0_ctrl_q <= `CCR_RST_BUCK0_CTRL;
         global_cfg_q <= `CCR_RST_GLOBAL_CFG;
         loaded_q <= 1'b0;
      end else if (!loaded_q) begin
         // Defaults from one-time memory
         limit_slew_q <= OTP_LIMIT_SLEW;
         vout0_q <= OTP_VOUT0;
         vout1_q <= OTP_VOUT1;
         step_up_q <= OTP_STEP_UP;
         delay0_q <= OTP_DELAY0;
         loaded_q <= 1'b1;
      end else if (ack_q && wr_lane) begin // Lands at the answer edge, where waitrequest is low
         // Address decode; unmapped and read-only addresses drop the write
         if (hit(AVS_ADDRESS, `CCR_IDX_LIMIT_SLEW)) begin
            limit_slew_q <= AVS_WRITEDATA[7:0];
         end else if (hit(AVS_ADDRESS, `CCR_IDX_VOUT0)) begin
            vout0_q <= AVS_WRITEDATA[7:0];
         end else if (hit(AVS_ADDRESS, `CCR_IDX_VOUT1)) begin
            vout1_q <= AVS_WRITEDATA[7:0];
         end else if (hit(AVS_ADDRESS, `CCR_IDX_STEP_UP)) begin
            step_up_q <= AVS_WRITEDATA[7:0];
         end else if (hit(AVS_ADDRESS, `CCR_IDX_DELAY0)) begin
            delay0_q <= AVS_WRITEDATA[7:0];
         end else if (hit(AVS_ADDRESS, `CCR_IDX_BUCK0_CTRL)) begin
            buck0_ctrl_q <= AVS_WRITEDATA[7:0];
         end else if (hit(AVS_ADDRESS, `CCR_IDX_GLOBAL_CFG)) begin
            global_cfg_q <= AVS_WRITEDATA[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read decode; unmapped addresses read zero
   always @* begin
      rd_mux = 8'h00;
      if (hit(AVS_ADDRESS, `CCR_IDX_LIMIT_SLEW)) begin
         rd_mux = {2'b00, limit_slew_q[5:0]}; // Reserved bits read zero
      end else if (hit(AVS_ADDRESS, `CCR_IDX_VOUT0)) begin
         rd_mux = vout0_q;
      end else if (hit(AVS_ADDRESS, `CCR_IDX_VOUT1)) begin
         rd_mux = vout1_q;
      end else if (hit(AVS_ADDRESS, `CCR_IDX_STEP_UP)) begin
         rd_mux = step_up_q;
      end else if (hit(AVS_ADDRESS, `CCR_IDX_DELAY0)) begin
         rd_mux = delay0_q;
      end else if (hit(AVS_ADDRESS, `CCR_IDX_BUCK0_CTRL)) begin
         rd_mux = {5'h00, buck0_ctrl_q[2:0]};
      end else if (hit(AVS_ADDRESS, `CCR_IDX_GLOBAL_CFG)) begin
         rd_mux = {7'h00, global_cfg_q[`CCR_SCALE_BIT]};
      end else if (hit(AVS_ADDRESS, `CCR_IDX_STATUS)) begin
         // Live state of the converters
         rd_mux = {4'h0, loaded_q, STEP_UP_DISCHARGE, STEP_UP_ON, FIRST_CONVERTER_ON};
      end
   end

   // Read data captured at the accept edge, stands through the answer
   always @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_q <= 8'h00;
      end else if (take && AVS_READ) begin
         rdata_q <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Enable gating with the synchronised pins
   assign step_up_eff = gate(step_up_q[`CCR_EN_BIT], step_up_q[`CCR_PINSEL_MSB:`CCR_PINSEL_LSB],
      pin_s2_q);
   assign buck0_ctrl_eff = gate(buck0_ctrl_q[`CCR_EN_BIT], buck0_ctrl_q[`CCR_PINSEL_MSB:`CCR_PINSEL_LSB],
      pin_s2_q);

   ////////////////////////////////////////////////////////////////////////
   // First buck sequencing
   ccr_delay_timer #(
      .STEP_CYCLES(STEP_CYCLES)
   ) u_buck0_timer (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .ctrl(buck0_ctrl_eff),
      .on_delay(delay0_q[`CCR_ON_DLY_MSB:`CCR_ON_DLY_LSB]),
      .off_delay(delay0_q[`CCR_OFF_DLY_MSB:`CCR_OFF_DLY_LSB]),
      .scale(global_cfg_q[`CCR_SCALE_BIT]),
      .active_q(FIRST_CONVERTER_ON)
   );

   ////////////////////////////////////////////////////////////////////////
   // Applied settings, registered; they follow the registers every cycle,
   // so a limit change reaches the converter even while it runs
   always @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SECOND_CONVERTER_PEAK_CURRENT_LIMIT <= 3'h0;
         SECOND_CONVERTER_LIMIT_MA <= `CCR_ILIM_BASE_MA;
         SECOND_CONVERTER_RAMP_RATE <= `CCR_SLEW_MIN;
         FIRST_CONVERTER_TARGET_MV <= `CCR_V_SEG1_MV;
         SECOND_CONVERTER_TARGET_MV <= `CCR_V_SEG1_MV;
         STEP_UP_TARGET_MV <= `CCR_SU_BASE_MV;
         STEP_UP_ON <= 1'b0;
         STEP_UP_DISCHARGE <= 1'b0;
      end else begin
         // Reserved limit code clamps to the highest legal limit
         if (limit_slew_q[`CCR_ILIM_MSB:`CCR_ILIM_LSB] > `CCR_ILIM_MAX) begin
            SECOND_CONVERTER_PEAK_CURRENT_LIMIT <= `CCR_ILIM_MAX;
            SECOND_CONVERTER_LIMIT_MA <= `CCR_ILIM_BASE_MA + {10'h000, `CCR_ILIM_MAX} * `CCR_ILIM_STEP_MA;
         end else begin
            SECOND_CONVERTER_PEAK_CURRENT_LIMIT <= limit_slew_q[`CCR_ILIM_MSB:`CCR_ILIM_LSB];
            SECOND_CONVERTER_LIMIT_MA <= `CCR_ILIM_BASE_MA
               + {10'h000, limit_slew_q[`CCR_ILIM_MSB:`CCR_ILIM_LSB]} * `CCR_ILIM_STEP_MA;
         end
         // Reserved ramp codes fall back to the fastest legal rate
         if (limit_slew_q[`CCR_SLEW_MSB:`CCR_SLEW_LSB] < `CCR_SLEW_MIN) begin
            SECOND_CONVERTER_RAMP_RATE <= `CCR_SLEW_MIN;
         end else begin
            SECOND_CONVERTER_RAMP_RATE <= limit_slew_q[`CCR_SLEW_MSB:`CCR_SLEW_LSB];
         end
         FIRST_CONVERTER_TARGET_MV <= vout_mv(vout0_q);
         SECOND_CONVERTER_TARGET_MV <= vout_mv(vout1_q);
         STEP_UP_TARGET_MV <= `CCR_SU_BASE_MV
            + {11'h000, step_up_q[`CCR_SU_VSET_MSB:`CCR_SU_VSET_LSB]} * `CCR_SU_STEP_MV;
         STEP_UP_ON <= step_up_eff;
         STEP_UP_DISCHARGE <= step_up_q[`CCR_SU_DISCH_BIT] & ~step_up_eff;
      end
   end

endmodule

// ===== verification/ccr_top_monitor.sv
// Checker for the converter configuration register bank.
// Assumes it is bound to ccr_top and sees only that module's ports.
`timescale 1ns/1ps

module ccr_top_monitor (
   // Clock and reset
   input wire REF_CLK,
   input wire RESET_N,
   // Register bus
   input wire [5:0] AVS_ADDRESS,
   input wire AVS_WRITE,
   input wire [3:0] AVS_BYTEENABLE,
   input wire [31:0] AVS_WRITEDATA,
   input wire AVS_WAITREQUEST,
   // Converter settings
   input wire [2:0] SECOND_CONVERTER_PEAK_CURRENT_LIMIT,
   input wire [12:0] SECOND_CONVERTER_LIMIT_MA,
   input wire [2:0] SECOND_CONVERTER_RAMP_RATE,
   input wire [11:0] FIRST_CONVERTER_TARGET_MV,
   input wire [11:0] SECOND_CONVERTER_TARGET_MV,
   input wire [12:0] STEP_UP_TARGET_MV,
   input wire STEP_UP_ON,
   input wire STEP_UP_DISCHARGE,
   input wire FIRST_CONVERTER_ON
);
   default clocking mon_cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   ////////////////////////////////////////////////////////////////////////////
   // Write completing on the low lane; register changes at this very edge
   wire wr_done = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
   wire [7:0] wd = AVS_WRITEDATA[7:0];

   // Millivolt map of a buck code; reserved low codes read as the floor
   function automatic [11:0] mv(input [7:0] c);
      if (c < 8'h14) mv = 12'd700;
      else if (c < 8'h18) mv = 12'd700 + 12'd10 * (c - 8'h14);
      else if (c < 8'h9E) mv = 12'd735 + 12'd5 * (c - 8'h18);
      else mv = 12'd1420 + 12'd20 * (c - 8'h9E);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Derived outputs land one edge after the register, so look two edges on
   limit_map_a:
   assert property (SECOND_CONVERTER_LIMIT_MA == 13'd1500 + 13'd500 * SECOND_CONVERTER_PEAK_CURRENT_LIMIT)
      else $error("limit current does not follow limit code");
   limit_range_a:
   assert property (SECOND_CONVERTER_PEAK_CURRENT_LIMIT <= 3'h6) else $error("reserved limit code applied");
   ramp_range_a:
   assert property (SECOND_CONVERTER_RAMP_RATE >= 3'h2) else $error("reserved ramp code applied");
   su_range_a:
   assert property (STEP_UP_TARGET_MV inside {13'd4900, 13'd5000, 13'd5100, 13'd5200})
      else $error("step-up target off the grid");
   discharge_excl_a:
   assert property (!(STEP_UP_ON && STEP_UP_DISCHARGE)) else $error("discharge while step-up on");
   vout_first_a:
   assert property (wr_done && AVS_ADDRESS == 6'h18 |-> ##2 FIRST_CONVERTER_TARGET_MV == mv($past(wd, 2)))
      else $error("first target wrong after write");
   vout_second_a:
   assert property (wr_done && AVS_ADDRESS == 6'h1C |-> ##2 SECOND_CONVERTER_TARGET_MV == mv($past(wd, 2)))
      else $error("second target wrong after write");
   limit_write_a:
   assert property (wr_done && AVS_ADDRESS == 6'h14 |-> ##2
      SECOND_CONVERTER_PEAK_CURRENT_LIMIT == ($past(wd[5:3], 2) == 3'h7 ? 3'h6 : $past(wd[5:3], 2)))
      else $error("limit code not applied after write");
   su_ungated_a:
   assert property (wr_done && AVS_ADDRESS == 6'h20 && wd[2:1] == 2'b00 |-> ##2
      (STEP_UP_ON == $past(wd[0], 2)) && (STEP_UP_DISCHARGE == ($past(wd[3], 2) && !$past(wd[0], 2))))
      else $error("step-up enable or discharge wrong");

   // Main scenarios
   cover property (wr_done && AVS_ADDRESS == 6'h18);
   cover property ($rose(STEP_UP_ON));
   cover property ($fell(FIRST_CONVERTER_ON));
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the converter configuration register bank.
// Assumes ccr_top with a short delay step and the monitor bound below.
`timescale 1ns/1ps

`define CHK(g, e) begin samples_checked = samples_checked + 1; if ((g) !== (e)) begin \
   mismatches = mismatches + 1; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
   localparam STEP = 10; // Short step keeps the longest wait to a few hundred cycles
   reg clk, rst_n, rd, wr;
   reg [5:0] addr;
   reg [3:0] be;
   reg [31:0] wd, seed, rdv;
   reg [7:0] otp [0:4]; // One-time memory defaults
   reg [7:0] regm [0:15]; // Register model
   reg [7:0] msk [0:15]; // Readable bits per index
   reg [8:0] cs [0:3]; // Sequencer cases: scale, off code, on code
   reg [2:0] pins;
   reg [7:0] c, c2;
   wire [31:0] rdata;
   wire wreq, su_on, su_dis, b0_on;
   wire [2:0] ilim, ramp;
   wire [12:0] lim_ma, su_mv;
   wire [11:0] v0_mv, v1_mv;
   integer mismatches, samples_checked, i, k, st, ex;

   ccr_top #(.STEP_CYCLES(STEP)) ccr_top_i (
      .REF_CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
      .OTP_LIMIT_SLEW(otp[0]), .OTP_VOUT0(otp[1]), .OTP_VOUT1(otp[2]), .OTP_STEP_UP(otp[3]),
      .OTP_DELAY0(otp[4]), .ENABLE_PIN_ONE(pins[0]), .ENABLE_PIN_TWO(pins[1]), .ENABLE_PIN_THREE(pins[2]),
      .SECOND_CONVERTER_PEAK_CURRENT_LIMIT(ilim), .SECOND_CONVERTER_LIMIT_MA(lim_ma),
      .SECOND_CONVERTER_RAMP_RATE(ramp), .FIRST_CONVERTER_TARGET_MV(v0_mv),
      .SECOND_CONVERTER_TARGET_MV(v1_mv), .STEP_UP_TARGET_MV(su_mv), .STEP_UP_ON(su_on),
      .STEP_UP_DISCHARGE(su_dis), .FIRST_CONVERTER_ON(b0_on));

   ////////////////////////////////////////////////////////////////////////////
   // Xorshift source with a fixed start
   function [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      xs = seed;
   endfunction

   // Millivolt map of a buck code
   function integer mv(input integer n);
      if (n < 20) mv = 700;
      else if (n < 24) mv = 700 + 10 * (n - 20);
      else if (n < 158) mv = 735 + 5 * (n - 24);
      else mv = 1420 + 20 * (n - 158);
   endfunction

   // Verdict and end of run
   task conclude;
      $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One Avalon transfer; held until waitrequest is sampled low
   task bus(input we, input [5:0] a, input [7:0] d);
      integer n;
      begin
         @(posedge clk);
         addr <= a; wd <= {24'h000000, d}; be <= 4'h1; wr <= we; rd <= !we;
         n = 0;
         // Waitrequest is looked at mid-cycle, where it has settled
         @(negedge clk);
         while (wreq !== 1'b0 && n < 50) begin
            n = n + 1;
            @(negedge clk);
         end
         // Answer edge: the write lands and read data is taken here
         @(posedge clk);
         rdv = rdata;
         wr <= 1'b0;
         rd <= 1'b0;
         // A hung slave ends the run
         if (n == 50) begin
            mismatches = mismatches + 1;
            conclude;
         end
      end
   endtask

   // Write that also updates the model
   task wreg(input [5:0] a, input [7:0] d);
      bus(1'b1, a, d);
      regm[a[5:2]] = d & msk[a[5:2]];
   endtask

   // Edges until the first converter reaches a level, bounded
   // Sampled mid-cycle so the launching edge never races the look
   task meas(input lvl);
      k = 0;
      while (b0_on !== lvl && k < 400) begin
         @(negedge clk);
         k = k + 1;
      end
      if (k == 400) begin
         mismatches = mismatches + 1;
         conclude;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Main sequence
   initial begin
      mismatches = 0; samples_checked = 0; seed = 70; rst_n = 1'b0; rd = 1'b0; wr = 1'b0;
      addr = 6'h00; be = 4'h0; wd = 32'h00000000; pins = 3'h0;
      for (i = 0; i < 16; i = i + 1) begin
         msk[i] = 8'h00;
      end
      msk[5] = 8'h3F; msk[6] = 8'hFF; msk[7] = 8'hFF; msk[8] = 8'hFF; msk[9] = 8'hFF; msk[12] = 8'h07; msk[13] = 8'h01;
      for (i = 0; i < 5; i = i + 1) begin
         otp[i] = xs();
         regm[i + 5] = otp[i] & msk[i + 5];
      end
      for (i = 10; i < 16; i = i + 1) begin
         regm[i] = 8'h00;
      end
      cs[0] = {1'b0, 4'h2, 4'h3}; cs[1] = {1'b1, 4'hF, 4'h1}; cs[2] = 9'h000; cs[3] = {1'b0, 4'h1, 4'hF};
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      // Defaults come from the one-time memory; unmapped indices read zero
      for (i = 5; i < 14; i = i + 1) begin
         bus(1'b0, i * 4, 8'h00);
         `CHK(rdv, {24'h000000, regm[i]})
      end
      `CHK(v0_mv, mv(otp[1]))
      $display("defaults test done");
      // Voltage map: segment boundaries, then random legal codes
      for (i = 0; i < 30; i = i + 1) begin
         c = (i < 6) ? ((i < 3) ? ((i == 0) ? 8'h14 : (i == 1) ? 8'h17 : 8'h18) :
             ((i == 3) ? 8'h9D : (i == 4) ? 8'h9E : 8'hFF)) : 8'h14 + (xs() % 236);
         c2 = 8'h14 + (xs() % 236);
         wreg(6'h18, c);
         wreg(6'h1C, c2);
         repeat (2) @(posedge clk);
         `CHK(v0_mv, mv(c))
         `CHK(v1_mv, mv(c2))
      end
      bus(1'b0, 6'h1C, 8'h00);
      `CHK(rdv, {24'h000000, regm[7]})
      $display("voltage test done");
      // Every limit and ramp code, back to back
      for (i = 0; i < 64; i = i + 1) begin
         wreg(6'h14, i);
         repeat (2) @(posedge clk);
         ex = (i / 8 == 7) ? 6 : i / 8;
         `CHK(ilim, ex)
         `CHK(lim_ma, 1500 + 500 * ex)
         `CHK(ramp, (i % 8 < 2) ? 2 : i % 8)
      end
      $display("limit test done");
      // Step-up: every voltage, discharge, source and enable setting with random pins
      for (i = 0; i < 64; i = i + 1) begin
         pins <= xs();
         c = {i[5:4], 2'b00, i[3:0]};
         wreg(6'h20, c);
         repeat (4) @(posedge clk);
         ex = c[0] && (c[2:1] == 2'b00 || pins[c[2:1] - 2'b01]);
         `CHK(su_on, ex)
         `CHK(su_dis, c[3] && ex == 0)
         `CHK(su_mv, 4900 + 100 * c[7:6])
      end
      $display("step-up test done");
      // Sequencing delays, both scales, zero and full codes
      pins <= 3'h0;
      for (i = 0; i < 4; i = i + 1) begin
         st = cs[i][8] ? 2 : 1;
         wreg(6'h34, cs[i][8]);
         wreg(6'h24, cs[i][7:0]);
         wreg(6'h30, 8'h01);
         meas(1'b1);
         ex = cs[i][3:0] * st * STEP + 4;
         `CHK(k >= ex - 3 && k <= ex + 3, 1'b1)
         wreg(6'h30, 8'h00);
         meas(1'b0);
         ex = cs[i][7:4] * st * STEP + 4;
         `CHK(k >= ex - 3 && k <= ex + 3, 1'b1)
      end
      // Pin-gated control holds the converter off until the pin rises
      wreg(6'h30, 8'h03);
      repeat (20) @(posedge clk);
      `CHK(b0_on, 1'b0)
      pins <= 3'h1;
      meas(1'b1);
      // Last on code still applies, plus two synchroniser edges
      ex = cs[3][3:0] * STEP + 5;
      `CHK(k >= ex - 3 && k <= ex + 3, 1'b1)
      // Status: loaded, discharge on (step-up pin three low), step-up off, first buck on
      bus(1'b0, 6'h38, 8'h00);
      `CHK(rdv, 32'h0000000D)
      $display("sequencer test done");
      conclude;
   end
endmodule

bind ccr_top ccr_top_monitor ccr_top_monitor_i (
   .REF_CLK(REF_CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
   .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .SECOND_CONVERTER_PEAK_CURRENT_LIMIT(SECOND_CONVERTER_PEAK_CURRENT_LIMIT),
   .SECOND_CONVERTER_LIMIT_MA(SECOND_CONVERTER_LIMIT_MA), .SECOND_CONVERTER_RAMP_RATE(SECOND_CONVERTER_RAMP_RATE),
   .FIRST_CONVERTER_TARGET_MV(FIRST_CONVERTER_TARGET_MV), .SECOND_CONVERTER_TARGET_MV(SECOND_CONVERTER_TARGET_MV),
   .STEP_UP_TARGET_MV(STEP_UP_TARGET_MV), .STEP_UP_ON(STEP_UP_ON), .STEP_UP_DISCHARGE(STEP_UP_DISCHARGE),
   .FIRST_CONVERTER_ON(FIRST_CONVERTER_ON));
